//--- toe_trigger_or_mask_engine.sv
// Trigger combining engine with APB register access.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// (R1) Trigger combines sources via AND and OR masks.
// (R2) Global enable gates every trigger source.
// (R3) Force command fires at once while waiting.
// (R4) Combined event passes a programmable delay.
// (R5) Source counts only when its mask bit set.
// (R6) OR mask has general and channel parts.
// (R7) General bits: 1h software, 2h/4h externals.
// (R8) 100h/200h extra inputs need expansion option.
// (R9) Software source fires right after start.
// (R10) External source fires on programmed condition.
// (R11) Sources are independent bits, combinable.
// (R12) General OR select resets to 1h.
// (R13) Software should clear unused general select.
// (R14) General availability register lists sources.
// (R15) Channel selects cover 0-31 and 32-63.
// (R16) Bit n enables channel n or n+32.
// (R17) Channel availability registers, low and high.
// (R18) Generator variants have no channel sources.
// (R19) OR output high when enabled source valid.
module toe_trigger_or_mask_engine #(
  parameter bit          IS_ACQUISITION = 1'b1,
  parameter bit          HAS_EXT1       = 1'b0,
  parameter bit          HAS_EXPANSION  = 1'b0,
  parameter int unsigned NUM_CHANNELS   = 4
) (
  input  wire logic                  mclk,
  input  wire logic                  resetn,
  input  wire toe_pkg::toe_apb_req_s apbReq,
  output var  toe_pkg::toe_apb_rsp_s apbRsp,
  input  wire logic                  externalTriggerInput0,
  input  wire logic                  externalTriggerInput1,
  input  wire logic                  extraTriggerInput0,
  input  wire logic                  extraTriggerInput1,
  input  wire logic [63:0]           chanTrig,
  output logic                       trigOut,
  output logic                       waitingOut
);

  localparam int unsigned DW = toe_pkg::DW;

  // Availability of the general sources on this variant.
  // (R14) availability mask
  localparam logic [DW-1:0] GEN_AVAIL =
    (DW'(1) << toe_pkg::SOFTWARE_SOURCE_BIT) |
    (DW'(1) << toe_pkg::EXTERNAL_IN0_BIT) |
    (DW'(HAS_EXT1) << toe_pkg::EXTERNAL_IN1_BIT) |
    (DW'(HAS_EXPANSION) << toe_pkg::EXTRA_IN0_BIT) |
    (DW'(HAS_EXPANSION) << toe_pkg::EXTRA_IN1_BIT);
  // (R18) no channels on generators
  localparam logic [63:0] CH_AVAIL = IS_ACQUISITION ?
    ((NUM_CHANNELS >= 64) ? {64{1'b1}} :
     ((64'h1 << NUM_CHANNELS) - 64'h1)) : 64'h0;

  logic rstSync1_ff;
  logic rstN;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rstSync1_ff <= 1'b0;
      rstN        <= 1'b0;
    end else begin
      rstSync1_ff <= 1'b1;
      rstN        <= rstSync1_ff;
    end
  end

  // Pin inputs: three stages, a high level counts once stages two and three
  // agree high, so a single-cycle high glitch is ignored; a low glitch drops it.
  logic [3:0] pinIn;
  logic [3:0] pinS1_ff;
  logic [3:0] pinS2_ff;
  logic [3:0] pinS3_ff;
  logic [3:0] pinLvl_ff;
  logic [3:0] pinPrev_ff;
  logic [3:0] pinEv;

  assign pinIn = {extraTriggerInput1, extraTriggerInput0,
                  externalTriggerInput1, externalTriggerInput0};

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      pinS1_ff   <= 4'h0;
      pinS2_ff   <= 4'h0;
      pinS3_ff   <= 4'h0;
      pinLvl_ff  <= 4'h0;
      pinPrev_ff <= 4'h0;
    end else begin
      pinS1_ff   <= pinIn;
      pinS2_ff   <= pinS1_ff;
      pinS3_ff   <= pinS2_ff;
      pinLvl_ff  <= (pinS2_ff & pinS3_ff) |
                    (pinLvl_ff & ~(pinS2_ff ^ pinS3_ff));
      pinPrev_ff <= pinLvl_ff;
    end
  end

  // Registers.
  logic [DW-1:0] orSel_ff;
  logic [DW-1:0] andSel_ff;
  logic [63:0]   chSel_ff;
  logic [63:0]   chAnd_ff;
  logic          enable_ff;
  logic [DW-1:0] delay_ff;
  logic [7:0]    detect_ff;
  logic          fired_ff;

  // (R10) per-input detect condition
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      unique case (toe_pkg::toe_detect_e'(detect_ff[i*2 +: 2]))
        toe_pkg::DET_RISE: pinEv[i] = pinLvl_ff[i] & ~pinPrev_ff[i];
        toe_pkg::DET_FALL: pinEv[i] = ~pinLvl_ff[i] & pinPrev_ff[i];
        toe_pkg::DET_HIGH: pinEv[i] = pinLvl_ff[i];
        toe_pkg::DET_LOW:  pinEv[i] = ~pinLvl_ff[i];
      endcase
    end
  end

  // APB slave: one wait state, the access completes on the second
  // access-phase edge.
  logic          acc;
  logic          done;
  logic          wrEn;
  logic          hitMap;
  logic [DW-1:0] rdVal;
  logic [15:0]   idx;
  logic          aligned;

  assign acc     = apbReq.psel & apbReq.penable;
  assign done    = acc & apbRsp.pready;
  assign wrEn    = done & apbReq.pwrite;
  assign idx     = apbReq.paddr[toe_pkg::AW-1:2];
  assign aligned = (apbReq.paddr[1:0] == 2'b00);

  logic                toe_stateWait;
  toe_pkg::toe_state_e state_ff;
  toe_pkg::toe_state_e nxt_state;
  logic [DW-1:0]       cnt_ff;
  logic [DW-1:0]       nxt_cnt;
  logic                nxt_trig;

  always_comb begin
    hitMap = aligned;
    unique case (idx)
      // (R14) general availability read
      toe_pkg::IDX_OR_AVAIL:    rdVal = GEN_AVAIL;
      toe_pkg::IDX_OR_SEL:      rdVal = orSel_ff;
      toe_pkg::IDX_AND_SEL:     rdVal = andSel_ff;
      // (R17) channel availability read
      toe_pkg::IDX_CH_AVAIL_LO: rdVal = CH_AVAIL[31:0];
      toe_pkg::IDX_CH_AVAIL_HI: rdVal = CH_AVAIL[63:32];
      toe_pkg::IDX_CH_SEL_LO:   rdVal = chSel_ff[31:0];
      toe_pkg::IDX_CH_SEL_HI:   rdVal = chSel_ff[63:32];
      toe_pkg::IDX_CH_AND_LO:   rdVal = chAnd_ff[31:0];
      toe_pkg::IDX_CH_AND_HI:   rdVal = chAnd_ff[63:32];
      toe_pkg::IDX_CONTROL:     rdVal = DW'(enable_ff);
      toe_pkg::IDX_STATUS: begin
        rdVal = '0;
        rdVal[toe_pkg::STAT_WAITING]  = (state_ff == toe_pkg::ST_WAIT);
        rdVal[toe_pkg::STAT_DELAYING] = (state_ff == toe_pkg::ST_DELAY);
        rdVal[toe_pkg::STAT_FIRED]    = fired_ff;
        rdVal[toe_pkg::STAT_ENABLE]   = enable_ff;
      end
      toe_pkg::IDX_DELAY:       rdVal = delay_ff;
      toe_pkg::IDX_DETECT:      rdVal = DW'(detect_ff);
      default: begin
        rdVal  = '0;
        hitMap = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      apbRsp <= '0;
    end else begin
      apbRsp.pready  <= acc & ~apbRsp.pready;
      if (acc && !apbRsp.pready) begin
        apbRsp.prdata  <= apbReq.pwrite ? '0 : (hitMap ? rdVal : '0);
        apbRsp.pslverr <= ~hitMap;
      end
    end
  end

  function automatic logic wrAt(input logic [15:0] at);
    wrAt = wrEn & aligned & (idx == at);
  endfunction

  logic wrCtrl;
  logic cmdForce;
  logic cmdStart;
  logic cmdAbort;
  logic cmdClr;

  assign wrCtrl   = wrAt(toe_pkg::IDX_CONTROL);
  assign cmdForce = wrCtrl & apbReq.pwdata[toe_pkg::CTRL_FORCE];
  assign cmdStart = wrCtrl & apbReq.pwdata[toe_pkg::CTRL_START];
  assign cmdAbort = wrCtrl & apbReq.pwdata[toe_pkg::CTRL_ABORT];
  assign cmdClr   = wrCtrl & apbReq.pwdata[toe_pkg::CTRL_CLR_FIRED];

  // (R11) whole-word mask writes
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      // (R12) software source by default
      orSel_ff  <= toe_pkg::OR_SEL_RST;
      andSel_ff <= toe_pkg::ZERO_RST;
      chSel_ff  <= 64'h0;
      chAnd_ff  <= 64'h0;
      enable_ff <= 1'b0;
      delay_ff  <= toe_pkg::ZERO_RST;
      detect_ff <= 8'h00;
    end else begin
      // (R7) general bits kept if present
      if (wrAt(toe_pkg::IDX_OR_SEL))
        orSel_ff <= apbReq.pwdata & GEN_AVAIL;
      if (wrAt(toe_pkg::IDX_AND_SEL))
        andSel_ff <= apbReq.pwdata & GEN_AVAIL &
                     ~(DW'(1) << toe_pkg::SOFTWARE_SOURCE_BIT);
      // (R15) low and high channel halves
      if (wrAt(toe_pkg::IDX_CH_SEL_LO))
        chSel_ff[31:0] <= apbReq.pwdata & CH_AVAIL[31:0];
      if (wrAt(toe_pkg::IDX_CH_SEL_HI))
        chSel_ff[63:32] <= apbReq.pwdata & CH_AVAIL[63:32];
      if (wrAt(toe_pkg::IDX_CH_AND_LO))
        chAnd_ff[31:0] <= apbReq.pwdata & CH_AVAIL[31:0];
      if (wrAt(toe_pkg::IDX_CH_AND_HI))
        chAnd_ff[63:32] <= apbReq.pwdata & CH_AVAIL[63:32];
      if (wrCtrl)
        enable_ff <= apbReq.pwdata[toe_pkg::CTRL_ENABLE];
      if (wrAt(toe_pkg::IDX_DELAY))
        delay_ff <= apbReq.pwdata;
      if (wrAt(toe_pkg::IDX_DETECT))
        detect_ff <= apbReq.pwdata[7:0];
    end
  end

  // Source vectors in register bit order.
  logic [DW-1:0] genEv;
  logic          orHit;
  logic          andHit;
  logic          srcHit;
  logic          fireEv;

  always_comb begin
    genEv = '0;
    // (R9) software source is always valid
    genEv[toe_pkg::SOFTWARE_SOURCE_BIT] = 1'b1;
    genEv[toe_pkg::EXTERNAL_IN0_BIT]    = pinEv[0];
    genEv[toe_pkg::EXTERNAL_IN1_BIT]    = pinEv[1];
    // (R8) extra inputs with expansion
    genEv[toe_pkg::EXTRA_IN0_BIT]       = pinEv[2];
    genEv[toe_pkg::EXTRA_IN1_BIT]       = pinEv[3];
  end

  // (R5) masked sources only
  // (R6) general and channel parts
  // (R16) bit n is channel n
  // (R19) any enabled valid source
  assign orHit  = (|(orSel_ff & genEv)) | (|(chSel_ff & chanTrig));
  assign andHit = ((andSel_ff != '0) || (chAnd_ff != 64'h0)) &&
                  ((genEv & andSel_ff) == andSel_ff) &&
                  ((chanTrig & chAnd_ff) == chAnd_ff);
  // (R1) AND and OR combined
  // (R2) global enable gate
  assign srcHit = enable_ff & (orHit | andHit);
  // (R3) force bypasses the sources
  assign fireEv = (state_ff == toe_pkg::ST_WAIT) & (srcHit | cmdForce);
  assign toe_stateWait = (nxt_state == toe_pkg::ST_WAIT);

  // (R4) delay before final trigger
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_trig  = 1'b0;
    unique case (state_ff)
      toe_pkg::ST_IDLE: begin
        if (cmdStart && !cmdAbort)
          nxt_state = toe_pkg::ST_WAIT;
      end
      toe_pkg::ST_WAIT: begin
        if (cmdAbort) begin
          nxt_state = toe_pkg::ST_IDLE;
        end else if (fireEv) begin
          if (delay_ff == '0) begin
            nxt_trig  = 1'b1;
            nxt_state = toe_pkg::ST_IDLE;
          end else begin
            nxt_cnt   = delay_ff;
            nxt_state = toe_pkg::ST_DELAY;
          end
        end
      end
      toe_pkg::ST_DELAY: begin
        nxt_cnt = cnt_ff - DW'(1);
        if (cmdAbort) begin
          nxt_state = toe_pkg::ST_IDLE;
        end else if (cnt_ff == DW'(1)) begin
          nxt_trig  = 1'b1;
          nxt_state = toe_pkg::ST_IDLE;
        end
      end
      default: nxt_state = toe_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      state_ff   <= toe_pkg::ST_IDLE;
      cnt_ff     <= '0;
      trigOut    <= 1'b0;
      waitingOut <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      cnt_ff     <= nxt_cnt;
      trigOut    <= nxt_trig;
      waitingOut <= toe_stateWait;
    end
  end

  // A trigger issued in the clearing cycle keeps the flag set.
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN)
      fired_ff <= 1'b0;
    else
      fired_ff <= nxt_trig | (fired_ff & ~cmdClr);
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstN);

  enable_gate_a: assert property ( // (R2)
    (state_ff == toe_pkg::ST_WAIT && !enable_ff && !cmdForce) |=>
    !trigOut && state_ff != toe_pkg::ST_DELAY)
    else $error("Trigger passed while disabled.");

  force_fire_a: assert property ( // (R3)
    (state_ff == toe_pkg::ST_WAIT && cmdForce && !cmdAbort &&
     delay_ff == '0) |=> trigOut)
    else $error("Force did not trigger.");

  delay_len_a: assert property ( // (R4)
    (fireEv && !cmdAbort && delay_ff == DW'(2)) |=>
    !trigOut ##1 !trigOut ##1 trigOut)
    else $error("Delay length wrong.");

  no_source_a: assert property ( // (R5)
    (state_ff == toe_pkg::ST_WAIT && orSel_ff == '0 &&
     chSel_ff == 64'h0 && andSel_ff == '0 && chAnd_ff == 64'h0 &&
     !cmdForce) |=> state_ff != toe_pkg::ST_DELAY && !trigOut)
    else $error("Trigger without a selected source.");

  sw_start_a: assert property ( // (R9)
    (state_ff == toe_pkg::ST_WAIT && enable_ff &&
     orSel_ff[toe_pkg::SOFTWARE_SOURCE_BIT] && !cmdAbort) |=>
    state_ff != toe_pkg::ST_WAIT)
    else $error("Software source did not fire.");

  or_reset_a: assert property ( // (R12)
    $rose(rstN) |-> orSel_ff == toe_pkg::OR_SEL_RST)
    else $error("General select reset value wrong.");

  ch_high_a: assert property ( // (R15)
    wrAt(toe_pkg::IDX_CH_SEL_HI) |=>
    chSel_ff[63:32] == ($past(apbReq.pwdata) & CH_AVAIL[63:32]))
    else $error("High channel select not stored.");

  ch_avail_a: assert property ( // (R18)
    (chSel_ff & ~CH_AVAIL) == 64'h0)
    else $error("Unavailable channel selected.");

  apb_ready_a: assert property (
    (acc && !apbRsp.pready) |=> apbRsp.pready ##1 !apbRsp.pready)
    else $error("Ready pulse malformed.");

endmodule : toe_trigger_or_mask_engine

`default_nettype wire

//--- toe_pkg.sv
// Constants, codes and bus carriers shared by the trigger OR mask engine.
package toe_pkg;

  localparam int unsigned AW = 18;
  localparam int unsigned DW = 32;

  // Register indices; the byte address is four times the index.
  localparam logic [15:0] IDX_OR_AVAIL    = 16'h9DD0;
  localparam logic [15:0] IDX_OR_SEL      = 16'h9DDA;
  localparam logic [15:0] IDX_AND_SEL     = 16'h9DEE;
  localparam logic [15:0] IDX_CH_AVAIL_LO = 16'h9E02;
  localparam logic [15:0] IDX_CH_AVAIL_HI = 16'h9E03;
  localparam logic [15:0] IDX_CH_SEL_LO   = 16'h9E0C;
  localparam logic [15:0] IDX_CH_SEL_HI   = 16'h9E0D;
  localparam logic [15:0] IDX_CH_AND_LO   = 16'h9E20;
  localparam logic [15:0] IDX_CH_AND_HI   = 16'h9E21;
  localparam logic [15:0] IDX_CONTROL     = 16'h9E54;
  localparam logic [15:0] IDX_STATUS      = 16'h9E55;
  localparam logic [15:0] IDX_DELAY       = 16'h9E56;
  localparam logic [15:0] IDX_DETECT      = 16'h9E57;

  // General source bit positions.
  localparam int unsigned SOFTWARE_SOURCE_BIT = 0;
  localparam int unsigned EXTERNAL_IN0_BIT    = 1;
  localparam int unsigned EXTERNAL_IN1_BIT    = 2;
  localparam int unsigned EXTRA_IN0_BIT       = 8;
  localparam int unsigned EXTRA_IN1_BIT       = 9;
  localparam logic [31:0] NO_SOURCE_CODE      = 32'h0000_0000;
  localparam logic [31:0] OR_SEL_RST          = 32'h0000_0001;
  localparam logic [31:0] ZERO_RST            = 32'h0000_0000;

  // Control bits; all but the enable are one-shot commands.
  localparam int unsigned CTRL_ENABLE    = 0;
  localparam int unsigned CTRL_FORCE     = 1;
  localparam int unsigned CTRL_START     = 2;
  localparam int unsigned CTRL_ABORT     = 3;
  localparam int unsigned CTRL_CLR_FIRED = 4;

  // Status bits.
  localparam int unsigned STAT_WAITING  = 0;
  localparam int unsigned STAT_DELAYING = 1;
  localparam int unsigned STAT_FIRED    = 2;
  localparam int unsigned STAT_ENABLE   = 3;

  // Detect mode field of each pin input, two bits each from bit 0 up:
  // external 0, external 1, extra 0, extra 1.
  localparam int unsigned DET_W = 2;

  typedef enum logic [1:0] {
    DET_RISE = 2'b00,
    DET_FALL = 2'b01,
    DET_HIGH = 2'b10,
    DET_LOW  = 2'b11
  } toe_detect_e;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_WAIT  = 2'b01,
    ST_DELAY = 2'b10
  } toe_state_e;

  typedef struct packed {
    logic [AW-1:0] paddr;
    logic          psel;
    logic          penable;
    logic          pwrite;
    logic [DW-1:0] pwdata;
  } toe_apb_req_s;

  typedef struct packed {
    logic [DW-1:0] prdata;
    logic          pready;
    logic          pslverr;
  } toe_apb_rsp_s;

endpackage : toe_pkg

//--- toe_trigger_or_mask_engine_tb.sv
// Self-checking testbench of the trigger OR mask engine.
`timescale 1ns/1ps
`default_nettype none
module toe_trigger_or_mask_engine_tb;
  typedef struct packed {
    logic [15:0] idx;
    logic        wr;
    logic [31:0] wd;
    logic [31:0] exp;
  } toe_reg_row_s;
  typedef struct packed {
    logic [31:0] orSel;
    logic [31:0] chSel;
    logic [63:0] chan;
    logic        en;
    logic        fire;
  } toe_trig_row_s;

  logic                  mclk;
  logic                  resetn;
  toe_pkg::toe_apb_req_s req;
  toe_pkg::toe_apb_rsp_s rsp;
  logic [3:0]            pin;
  logic [63:0]           chanTrig;
  logic                  trigOut;
  logic                  waitingOut;
  int                    n_mismatch;
  int                    compares;
  logic [31:0]           rd;
  logic                  err;
  logic                  fired;
  int                    lat0;
  int                    lat5;
  toe_reg_row_s          regRows [8];
  toe_trig_row_s         trigRows [7];
  logic [31:0]           pinBits [4];

  toe_trigger_or_mask_engine #(
    .IS_ACQUISITION (1'h1),
    .HAS_EXT1       (1'h1),
    .HAS_EXPANSION  (1'h1),
    .NUM_CHANNELS   (4)
  ) dut (
    .mclk                  (mclk),
    .resetn                (resetn),
    .apbReq                (req),
    .apbRsp                (rsp),
    .externalTriggerInput0 (pin[0]),
    .externalTriggerInput1 (pin[1]),
    .extraTriggerInput0    (pin[2]),
    .extraTriggerInput1    (pin[3]),
    .chanTrig              (chanTrig),
    .trigOut               (trigOut),
    .waitingOut            (waitingOut)
  );

  initial begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // The slave answers when it is ready; the bench only bounds the wait.
  task automatic apb(input logic wr, input logic [15:0] idx,
                     input logic [31:0] wd);
    int n;
    @(posedge mclk);
    req.paddr   <= {idx, 2'h0};
    req.pwrite  <= wr;
    req.pwdata  <= wd;
    req.psel    <= 1'h1;
    req.penable <= 1'h0;
    @(posedge mclk);
    req.penable <= 1'h1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (rsp.pready !== 1'h1 && n < 20);
    chk(32'(rsp.pready), 32'h1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel    <= 1'h0;
    req.penable <= 1'h0;
  endtask : apb

  task automatic poll(output logic f, output int l);
    f = 1'h0;
    l = 0;
    for (int i = 0; i < 30; i++) begin
      #1;
      if (!f && trigOut === 1'h1) begin
        f = 1'h1;
        l = i;
      end
      @(posedge mclk);
    end
  endtask : poll

  task automatic arm(input logic [31:0] orSel, input logic [31:0] chSel,
                     input logic [31:0] ctrl, input logic [31:0] dly,
                     output int l);
    apb(1'h1, toe_pkg::IDX_OR_SEL, orSel);
    apb(1'h1, toe_pkg::IDX_CH_SEL_LO, chSel);
    apb(1'h1, toe_pkg::IDX_DELAY, dly);
    apb(1'h1, toe_pkg::IDX_CONTROL, ctrl);
    #1;
    chk(32'(waitingOut), 32'h1);
    poll(fired, l);
  endtask : arm

  // Abort, clear the sticky flag and let the pin synchronisers settle.
  task automatic tidy();
    apb(1'h1, toe_pkg::IDX_CONTROL, 32'h18);
    chanTrig <= 64'h0;
    pin      <= 4'h0;
    repeat (6) @(posedge mclk);
  endtask : tidy

  task automatic print_verdict();
    $display("counts: %0d compares, %0d mismatches", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict

  initial begin
    #100000;
    n_mismatch++;
    print_verdict();
  end

  initial begin
    resetn = 1'h0;
    req = '0;
    pin = 4'h0;
    chanTrig = 64'h0;
    n_mismatch = 0;
    compares = 0;
    regRows = '{
      '{toe_pkg::IDX_OR_AVAIL, 1'h0, 32'h0, 32'h307},
      '{toe_pkg::IDX_CH_AVAIL_LO, 1'h0, 32'h0, 32'hF},
      '{toe_pkg::IDX_CH_AVAIL_HI, 1'h0, 32'h0, 32'h0},
      '{toe_pkg::IDX_OR_SEL, 1'h1, 32'hFFFFFFFF, 32'h307},
      '{toe_pkg::IDX_OR_SEL, 1'h1, 32'h0, 32'h0},
      '{toe_pkg::IDX_CH_SEL_LO, 1'h1, 32'hFFFFFFFF, 32'hF},
      '{toe_pkg::IDX_CH_SEL_HI, 1'h1, 32'hFFFFFFFF, 32'h0},
      '{toe_pkg::IDX_OR_AVAIL, 1'h1, 32'h0, 32'h307}};
    trigRows = '{
      '{32'h1, 32'h0, 64'h0, 1'h1, 1'h1},
      '{32'h0, 32'h1, 64'h1, 1'h1, 1'h1},
      '{32'h0, 32'h2, 64'h1, 1'h1, 1'h0},
      '{32'h0, 32'h1, 64'h1, 1'h0, 1'h0},
      '{32'h1, 32'h0, 64'h0, 1'h0, 1'h0},
      '{32'h0, 32'h8, 64'h8, 1'h1, 1'h1},
      '{32'h0, 32'h0, 64'hF, 1'h1, 1'h0}};
    pinBits = '{32'h2, 32'h4, 32'h100, 32'h200};
    repeat (5) @(posedge mclk);
    resetn <= 1'h1;
    repeat (3) @(posedge mclk);
    #1;
    chk(32'(trigOut), 32'h0);
    chk(32'(waitingOut), 32'h0);
    apb(1'h0, toe_pkg::IDX_OR_SEL, 32'h0);
    chk(rd, toe_pkg::OR_SEL_RST);
    apb(1'h0, toe_pkg::IDX_CH_SEL_LO, 32'h0);
    chk(rd, 32'h0);
    apb(1'h0, toe_pkg::IDX_CH_SEL_HI, 32'h0);
    chk(rd, 32'h0);
    $display("test reset done");
    foreach (regRows[i]) begin
      if (regRows[i].wr) apb(1'h1, regRows[i].idx, regRows[i].wd);
      apb(1'h0, regRows[i].idx, 32'h0);
      chk(rd, regRows[i].exp);
    end
    apb(1'h0, 16'h9DD1, 32'h0);
    chk(32'(err), 32'h1);
    chk(rd, 32'h0);
    $display("test registers done");
    // Masked sources and the global enable.
    foreach (trigRows[i]) begin
      chanTrig <= trigRows[i].chan;
      arm(trigRows[i].orSel, trigRows[i].chSel,
          {29'h0, 1'h1, 1'h0, trigRows[i].en}, 32'h0, lat0);
      chk(32'(fired), 32'(trigRows[i].fire));
      if (fired) chk(32'(waitingOut), 32'h0);
      tidy();
    end
    $display("test trigger table done");
    arm(32'h1, 32'h0, 32'h5, 32'h0, lat0);
    tidy();
    arm(32'h1, 32'h0, 32'h5, 32'h5, lat5);
    tidy();
    chk(32'(lat5 - lat0), 32'h5);
    arm(32'h1, 32'h0, 32'h5, 32'h2, lat5);
    tidy();
    chk(32'(lat5 - lat0), 32'h2);
    $display("test delay done");
    arm(32'h0, 32'h0, 32'h4, 32'h0, lat0);
    chk(32'(fired), 32'h0);
    apb(1'h1, toe_pkg::IDX_CONTROL, 32'h2);
    poll(fired, lat0);
    chk(32'(fired), 32'h1);
    apb(1'h0, toe_pkg::IDX_STATUS, 32'h0);
    chk(rd, 32'h4);
    tidy();
    apb(1'h0, toe_pkg::IDX_STATUS, 32'h0);
    chk(rd, 32'h0);
    apb(1'h1, toe_pkg::IDX_CONTROL, 32'h2);
    poll(fired, lat0);
    chk(32'(fired), 32'h0);
    $display("test force done");
    // Pin sources fire on a rising edge.
    for (int k = 0; k < 4; k++) begin
      arm(pinBits[k], 32'h0, 32'h5, 32'h0, lat0);
      chk(32'(fired), 32'h0);
      pin[k] <= 1'h1;
      poll(fired, lat0);
      chk(32'(fired), 32'h1);
      tidy();
    end
    $display("test pins done");
    // Low, high and falling detect modes on external input 0.
    apb(1'h1, toe_pkg::IDX_DETECT, 32'h3);
    arm(32'h2, 32'h0, 32'h5, 32'h0, lat0);
    chk(32'(fired), 32'h1);
    tidy();
    pin[0] <= 1'h1;
    apb(1'h1, toe_pkg::IDX_DETECT, 32'h2);
    repeat (6) @(posedge mclk);
    arm(32'h2, 32'h0, 32'h5, 32'h0, lat0);
    chk(32'(fired), 32'h1);
    apb(1'h1, toe_pkg::IDX_CONTROL, 32'h18);
    apb(1'h1, toe_pkg::IDX_DETECT, 32'h1);
    arm(32'h2, 32'h0, 32'h5, 32'h0, lat0);
    chk(32'(fired), 32'h0);
    pin[0] <= 1'h0;
    poll(fired, lat0);
    chk(32'(fired), 32'h1);
    tidy();
    apb(1'h1, toe_pkg::IDX_DETECT, 32'h0);
    $display("test detect modes done");
    // The channel AND mask needs every selected channel.
    apb(1'h1, toe_pkg::IDX_CH_AND_LO, 32'h3);
    chanTrig <= 64'h1;
    arm(32'h0, 32'h0, 32'h5, 32'h0, lat0);
    chk(32'(fired), 32'h0);
    chanTrig <= 64'h3;
    poll(fired, lat0);
    chk(32'(fired), 32'h1);
    tidy();
    apb(1'h1, toe_pkg::IDX_CH_AND_LO, 32'h0);
    $display("test and mask done");
    // A reset in mid-run restores the software selection.
    apb(1'h1, toe_pkg::IDX_OR_SEL, 32'h0);
    resetn <= 1'h0;
    repeat (5) @(posedge mclk);
    resetn <= 1'h1;
    repeat (3) @(posedge mclk);
    apb(1'h0, toe_pkg::IDX_OR_SEL, 32'h0);
    chk(rd, toe_pkg::OR_SEL_RST);
    $display("test mid-run reset done");
    print_verdict();
  end
endmodule : toe_trigger_or_mask_engine_tb
`default_nettype wire
